/* logic/xcs_consts.vh */
// Purpose: shared constants for the x21 call-setup channel
// Assumes: 8-bit characters, one channel, 20 MHz i_mclk
// Notes: option bit positions follow the channel option registers b and c
//
// Notes on behaviour
// - steady-state detection works only while steady_state_detect_en is set; a validated sync pair still loads o_cond_class with it clear
// - with repeat_command_mode set, transmit byte 80 hex opens a four-byte command
// - command byte two: 00 drives control lead off, 01 on, others reserved
// - command byte three is sent unchanged, no parity added by the channel
// - command byte four is repeat count; zero repeats until new data arrives
// - zero count still sends the character at least three times
// - receiver forwards only changes between validated steady conditions
// - steady conditions: ones, zeros, alternating, sync char, three special chars
// - validation needs two consecutive character times with stable indication lead
// - sync strip and special detect enables need steady detect enable too
// - with strip on, two syncs raise interrupt, further syncs are discarded
// - with strip off, syncs still synchronise and are passed as data
// - special char seen twice raises interrupt, repeats dropped until state change
// - special characters are matched only after character synchronisation
// - partial character before sync or steady state is passed as data
// - characters before sync are forwarded, except repeats of validated ones, zeros or alternating
// - extended mode keeps delivering characters while hunting for sync
// - sync character register defaults to 16 hex after initialisation
`ifndef XCS_CONSTS_VH
`define XCS_CONSTS_VH

`define XCS_CMD_START      8'h80
`define XCS_LEAD_OFF       8'h00
`define XCS_LEAD_ON        8'h01
`define XCS_SYNC_RESET     8'h16
`define XCS_MIN_REPEAT     2'h3
`define XCS_VALID_CHARS    2'h2
`define XCS_ONES           8'hFF
`define XCS_ZEROS          8'h00
`define XCS_ALT_A          8'h55
`define XCS_ALT_B          8'hAA
`define XCS_ORB_CMD_BIT    5
`define XCS_ORC_SINGLE_BIT 7
`define XCS_ORC_STEADY_BIT 6
`define XCS_ORC_STRIP_BIT  5
`define XCS_ORC_SPEC_BIT   4
// condition classes
`define XCS_C_NONE         3'h0
`define XCS_C_ONES         3'h1
`define XCS_C_ZEROS        3'h2
`define XCS_C_ALT          3'h3
`define XCS_C_SYNC         3'h4
`define XCS_C_SPEC         3'h5

`endif

/* logic/xcs_tx_repeat.v */
// Purpose: transmit side, decodes embedded repeat commands
// Assumes: host bytes arrive with valid/ready; line takes bytes with valid/ready
// Notes: control lead output is registered; of the command bytes only the repeated character reaches the line
`include "xcs_consts.vh"
`default_nettype none

module xcs_tx_repeat (
  input  wire       i_mclk,
  input  wire       i_rst,
  input  wire       i_cmd_en,
  input  wire [7:0] i_tx_data,
  input  wire       i_tx_valid,
  output wire       o_tx_ready,
  output reg  [7:0] o_line_data,
  output reg        o_line_valid,
  input  wire       i_line_ready,
  output reg        o_ctrl_lead
);

  localparam [2:0] ST_DATA  = 3'h0;
  localparam [2:0] ST_LEAD  = 3'h1;
  localparam [2:0] ST_CHAR  = 3'h2;
  localparam [2:0] ST_COUNT = 3'h3;
  localparam [2:0] ST_REP   = 3'h4;

  reg [2:0] state_r;
  reg [7:0] rep_char_r;
  reg [7:0] rep_cnt_r;
  reg       rep_forever_r;
  reg [1:0] sent_r;

  wire line_free = !o_line_valid || i_line_ready;
  // a zero-count repeat may end only once the minimum count is out; waiting data is taken after
  // the return to data state, since the repeat state has nowhere to store a byte
  wire rep_busy  = (state_r == ST_REP) &&
                   (!rep_forever_r || sent_r < `XCS_MIN_REPEAT);
  assign o_tx_ready = line_free && (state_r != ST_REP);
  wire take = i_tx_valid && o_tx_ready;

  ////////////////////////////////////////////////////////////////////////
  // command decoder and output byte register
  always @(posedge i_mclk) begin
    if (i_rst) begin
      state_r       <= ST_DATA;
      rep_char_r    <= 8'h00;
      rep_cnt_r     <= 8'h00;
      rep_forever_r <= 1'b0;
      sent_r        <= 2'h0;
      o_line_data   <= 8'h00;
      o_line_valid  <= 1'b0;
      o_ctrl_lead   <= 1'b0;
    end else begin
      if (i_line_ready)
        o_line_valid <= 1'b0;
      case (state_r)
        ST_DATA: begin
          if (take) begin
            if (i_cmd_en && i_tx_data == `XCS_CMD_START) begin
              state_r <= ST_LEAD;
            end else begin
              o_line_data  <= i_tx_data;  // unaltered
              o_line_valid <= 1'b1;
            end
          end
        end
        ST_LEAD: begin
          if (take) begin
            if (i_tx_data == `XCS_LEAD_OFF)
              o_ctrl_lead <= 1'b0;
            else if (i_tx_data == `XCS_LEAD_ON)
              o_ctrl_lead <= 1'b1;
            state_r <= ST_CHAR;     // reserved keeps the lead
          end
        end
        ST_CHAR: begin
          if (take) begin
            rep_char_r <= i_tx_data;  // kept verbatim
            state_r    <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (take) begin
            rep_cnt_r     <= i_tx_data;
            rep_forever_r <= (i_tx_data == 8'h00);
            sent_r        <= 2'h0;
            state_r       <= ST_REP;
          end
        end
        ST_REP: begin
          if (line_free) begin
            if (!rep_forever_r && rep_cnt_r == 8'h00) begin
              state_r <= ST_DATA;
            end else if (rep_forever_r && !rep_busy && i_tx_valid) begin
              state_r <= ST_DATA;  // new data ends the repeat
            end else begin
              o_line_data  <= rep_char_r;
              o_line_valid <= 1'b1;
              if (!rep_forever_r)
                rep_cnt_r <= rep_cnt_r - 8'h01;
              if (sent_r != `XCS_MIN_REPEAT)
                sent_r <= sent_r + 2'h1;
            end
          end
        end
        default: state_r <= ST_DATA;
      endcase
    end
  end

endmodule

`default_nettype wire

/* logic/xcs_channel.v */
// Purpose: x21 call-setup channel: transmit repeat commands, receive steady-state filter
// Assumes: received characters arrive as one-cycle strobes with a partial-character flag
// Notes: indication lead is a pin and is synchronised; outputs are registered
`include "xcs_consts.vh"
`default_nettype none

module xcs_channel (
  input  wire       i_mclk,
  input  wire       i_rst,
  // option bits
  input  wire [7:0] i_channel_option_reg_b,
  input  wire [7:0] i_channel_option_reg_c,
  input  wire [7:0] i_sync_char_wdata,
  input  wire       i_sync_char_we,
  input  wire [7:0] i_special_char_1,
  input  wire [7:0] i_special_char_2,
  input  wire [7:0] i_special_char_3,
  input  wire       i_extended_mode,
  // transmit host side
  input  wire [7:0] i_tx_data,
  input  wire       i_tx_valid,
  output reg        o_tx_ready,
  // transmit line side
  output reg  [7:0] o_line_tx_data,
  output reg        o_line_tx_valid,
  input  wire       i_line_tx_ready,
  output reg        o_ctrl_lead,
  // receive line side
  input  wire [7:0] i_rx_char,
  input  wire       i_rx_strobe,
  input  wire       i_rx_partial,
  input  wire       i_indication_lead,
  // receive host side
  output reg  [7:0] o_rx_data,
  output reg        o_rx_valid,
  output reg  [2:0] o_cond_class,
  output reg        o_cond_change,
  output reg        o_sync_irq,
  output reg        o_special_irq,
  output reg        o_char_synced,
  output reg  [7:0] o_sync_char
);

  ////////////////////////////////////////////////////////////////////////
  // option bit decode
  wire steady_en  = i_channel_option_reg_c[`XCS_ORC_STEADY_BIT];
  wire strip_en   = steady_en && i_channel_option_reg_c[`XCS_ORC_STRIP_BIT];
  wire special_en = steady_en && i_channel_option_reg_c[`XCS_ORC_SPEC_BIT];
  wire cmd_en    = i_channel_option_reg_b[`XCS_ORB_CMD_BIT];

  ////////////////////////////////////////////////////////////////////////
  // transmit path; its handshake is registered here so top outputs are flops
  wire       tx_ready_w;
  wire [7:0] tx_data_w;
  wire       tx_valid_w;
  wire       lead_w;
  reg  [7:0] tx_hold_r;
  reg        tx_hold_v_r;
  wire       tx_take  = i_tx_valid && o_tx_ready;
  wire       sub_take = tx_hold_v_r && tx_ready_w;
  // the decoder hands a byte on only when the output stage can take it this edge
  wire       line_room = !o_line_tx_valid || i_line_tx_ready;

  xcs_tx_repeat u_tx (
    .i_mclk       (i_mclk),
    .i_rst        (i_rst),
    .i_cmd_en     (cmd_en),
    .i_tx_data    (tx_hold_r),
    .i_tx_valid   (tx_hold_v_r),
    .o_tx_ready   (tx_ready_w),
    .o_line_data  (tx_data_w),
    .o_line_valid (tx_valid_w),
    .i_line_ready (line_room),
    .o_ctrl_lead  (lead_w)
  );

  // one-byte skid stage; costs a cycle of latency but keeps outputs registered
  always @(posedge i_mclk) begin
    if (i_rst) begin
      tx_hold_r       <= 8'h00;
      tx_hold_v_r     <= 1'b0;
      o_tx_ready      <= 1'b0;
      o_line_tx_data  <= 8'h00;
      o_line_tx_valid <= 1'b0;
      o_ctrl_lead     <= 1'b0;
    end else begin
      if (tx_take) begin
        tx_hold_r   <= i_tx_data;
        tx_hold_v_r <= 1'b1;
      end else if (sub_take) begin
        tx_hold_v_r <= 1'b0;
      end
      o_tx_ready      <= !(tx_hold_v_r && !sub_take) && !tx_take;
      // output stage reloads only when empty or emptied at this edge, so a stalled byte holds
      if (line_room) begin
        o_line_tx_data  <= tx_data_w;
        o_line_tx_valid <= tx_valid_w;
      end
      o_ctrl_lead     <= lead_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // indication lead synchroniser, two flops before any use
  reg lead_s1_r;
  reg lead_s2_r;
  always @(posedge i_mclk) begin
    if (i_rst) begin
      lead_s1_r <= 1'b0;
      lead_s2_r <= 1'b0;
    end else begin
      lead_s1_r <= i_indication_lead;
      lead_s2_r <= lead_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sync character register, reloads its default on reset
  always @(posedge i_mclk) begin
    if (i_rst)
      o_sync_char <= `XCS_SYNC_RESET;
    else if (i_sync_char_we)
      o_sync_char <= i_sync_char_wdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // classify each received character
  wire [7:0] spec [0:2];
  assign spec[0] = i_special_char_1;
  assign spec[1] = i_special_char_2;
  assign spec[2] = i_special_char_3;
  wire [2:0] spec_hit;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_spec
      assign spec_hit[g] = (i_rx_char == spec[g]);
    end
  endgenerate

  reg [2:0] cls;
  always @* begin
    cls = `XCS_C_NONE;
    if (i_rx_char == o_sync_char)
      cls = `XCS_C_SYNC;
    else if (o_char_synced && special_en && |spec_hit)
      cls = `XCS_C_SPEC;
    else if (steady_en && i_rx_char == `XCS_ONES)
      cls = `XCS_C_ONES;
    else if (steady_en && i_rx_char == `XCS_ZEROS)
      cls = `XCS_C_ZEROS;
    else if (steady_en && (i_rx_char == `XCS_ALT_A || i_rx_char == `XCS_ALT_B))
      cls = `XCS_C_ALT;
  end

  ////////////////////////////////////////////////////////////////////////
  // persistence tracking: same class, character and lead for two characters
  reg [2:0] cand_cls_r;
  reg [7:0] cand_char_r;
  reg       cand_lead_r;
  reg [1:0] cand_cnt_r;
  reg [2:0] valid_cls_r;
  reg [7:0] valid_char_r;
  reg       valid_lead_r;

  wire same     = (cls == cand_cls_r) && (i_rx_char == cand_char_r) &&
                  (lead_s2_r == cand_lead_r);
  wire [1:0] cnt_nxt   = same ? ((cand_cnt_r == `XCS_VALID_CHARS) ? cand_cnt_r
                                                                 : cand_cnt_r + 2'h1)
                              : 2'h1;
  wire validated = (cls != `XCS_C_NONE) && (cnt_nxt == `XCS_VALID_CHARS);
  wire is_change = validated && ((cls != valid_cls_r) || (i_rx_char != valid_char_r) ||
                                 (lead_s2_r != valid_lead_r));
  wire in_steady = (cls != `XCS_C_NONE) && (cls == valid_cls_r) &&
                   (i_rx_char == valid_char_r) && (lead_s2_r == valid_lead_r);

  // drop decision: repeats of an established condition are not forwarded, syncs only with strip on
  reg drop;
  always @* begin
    drop = 1'b0;
    case (cls)
      `XCS_C_SYNC:  drop = strip_en && o_char_synced;
      `XCS_C_SPEC:  drop = special_en && (validated || in_steady);
      `XCS_C_ONES,
      `XCS_C_ZEROS,
      `XCS_C_ALT:   drop = validated || in_steady;
      default:      drop = 1'b0;  // unclassified characters pass
    endcase
    if (i_rx_partial)
      drop = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // receive state and host outputs
  always @(posedge i_mclk) begin
    if (i_rst) begin
      cand_cls_r    <= `XCS_C_NONE;
      cand_char_r   <= 8'h00;
      cand_lead_r   <= 1'b0;
      cand_cnt_r    <= 2'h0;
      valid_cls_r   <= `XCS_C_NONE;
      valid_char_r  <= 8'h00;
      valid_lead_r  <= 1'b0;
      o_char_synced <= 1'b0;
      o_rx_data     <= 8'h00;
      o_rx_valid    <= 1'b0;
      o_cond_class  <= `XCS_C_NONE;
      o_cond_change <= 1'b0;
      o_sync_irq    <= 1'b0;
      o_special_irq <= 1'b0;
    end else begin
      o_rx_valid    <= 1'b0;
      o_cond_change <= 1'b0;
      o_sync_irq    <= 1'b0;
      o_special_irq <= 1'b0;
      if (i_rx_strobe) begin
        cand_cls_r  <= cls;
        cand_char_r <= i_rx_char;
        cand_lead_r <= lead_s2_r;
        cand_cnt_r  <= cnt_nxt;
        // two consecutive syncs give character sync, even with strip off
        if (cls == `XCS_C_SYNC && cnt_nxt == `XCS_VALID_CHARS)
          o_char_synced <= 1'b1;
        else if (validated && cls != `XCS_C_SYNC && cls != `XCS_C_SPEC)
          o_char_synced <= 1'b0;  // a steady line pattern drops char sync
        if (is_change) begin
          valid_cls_r   <= cls;
          valid_char_r  <= i_rx_char;
          valid_lead_r  <= lead_s2_r;
          o_cond_class  <= cls;
          o_cond_change <= (cls != `XCS_C_SYNC) || strip_en;
          o_sync_irq    <= (cls == `XCS_C_SYNC) && strip_en;
          o_special_irq <= (cls == `XCS_C_SPEC);
        end
        if (!drop) begin
          o_rx_data  <= i_rx_char;
          o_rx_valid <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* verification/xcs_chk.sv */
// Purpose: port-level assertions for xcs_channel
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to every xcs_channel instance; watches ports only
`default_nettype none
module xcs_chk (
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic [7:0] i_channel_option_reg_c,
  input wire logic [7:0] i_rx_char,
  input wire logic       i_rx_strobe,
  input wire logic       i_rx_partial,
  input wire logic       i_line_tx_ready,
  input wire logic [7:0] o_line_tx_data,
  input wire logic       o_line_tx_valid,
  input wire logic [7:0] o_rx_data,
  input wire logic       o_rx_valid,
  input wire logic       o_cond_change,
  input wire logic       o_sync_irq,
  input wire logic       o_special_irq,
  input wire logic       o_char_synced,
  input wire logic [7:0] o_sync_char
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // a stalled line byte must stay put, or the far end sees a changed character
  a_line_hold_stable: assert property (
    o_line_tx_valid && !i_line_tx_ready |=> o_line_tx_valid && $stable(o_line_tx_data))
    else $error("line byte moved while stalled");
  // every forwarded byte is the character strobed one cycle before
  a_rx_fwd_cause: assert property (
    o_rx_valid |-> $past(i_rx_strobe) && o_rx_data == $past(i_rx_char))
    else $error("forwarded byte has no matching strobe");
  a_partial_fwd: assert property (
    i_rx_strobe && i_rx_partial |=> o_rx_valid && o_rx_data == $past(i_rx_char))
    else $error("partial character not forwarded");
  // with detection off nothing may be filtered
  a_no_detect_fwd: assert property (
    i_rx_strobe && !i_channel_option_reg_c[6] |=> o_rx_valid)
    else $error("character dropped with detection off");
  a_change_needs_steady_state_detect_en: assert property (
    o_cond_change |-> $past(i_channel_option_reg_c[6]))
    else $error("condition change with detection off");
  a_sync_irq_strip: assert property (
    o_sync_irq |-> $past(i_channel_option_reg_c[6] && i_channel_option_reg_c[5]) && $past(i_rx_strobe))
    else $error("sync interrupt without strip enabled");
  a_special_after_sync: assert property (
    o_special_irq |-> $past(o_char_synced) && $past(i_channel_option_reg_c[6] && i_channel_option_reg_c[4]))
    else $error("special interrupt before sync or while disabled");
  a_change_single: assert property (
    o_cond_change |=> !o_cond_change)
    else $error("condition change pulsed twice");
  a_sync_reset_val: assert property (
    $fell(i_rst) |-> o_sync_char == 8'h16)
    else $error("sync char not at reset value");
endmodule
bind xcs_channel xcs_chk chk_i (.i_mclk, .i_rst, .i_channel_option_reg_c, .i_rx_char, .i_rx_strobe,
  .i_rx_partial, .i_line_tx_ready, .o_line_tx_data, .o_line_tx_valid, .o_rx_data, .o_rx_valid,
  .o_cond_change, .o_sync_irq, .o_special_irq, .o_char_synced, .o_sync_char);
`default_nettype wire

/* verification/xcs_line_model.sv */
// Purpose: line-side partner that takes transmit bytes
// Assumes: byte handshake with valid held until ready
// Notes: slow mode stalls at random, as a busy line would
`default_nettype none
module xcs_line_model (
  input  wire logic       i_mclk,
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  input  wire logic       i_slow,
  output var  logic       o_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got [0:63];
  int         n_got = 0;
  initial o_ready = 1'b1;
  // log each accepted byte; capped so a runaway repeat cannot overrun
  always @(posedge i_mclk) begin
    o_ready <= i_slow ? 1'($urandom_range(0, 1)) : 1'b1;
    if (i_valid === 1'b1 && o_ready === 1'b1 && n_got < 64) begin
      got[n_got] <= i_data;
      n_got <= n_got + 1;
    end
  end
endmodule
`default_nettype wire

/* verification/xcs_channel_tb_top.sv */
// Purpose: self-checking bench for xcs_channel
// Assumes: line model takes transmit bytes; bench drives received characters
// Notes: junk and data bytes come from a fixed seed
`default_nettype none
module xcs_channel_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       i_mclk = 1'b0;
  logic       i_rst = 1'b1;
  logic [7:0] opt_b = 8'h00;
  logic [7:0] opt_c = 8'h00;
  logic [7:0] sc_wd = 8'h00;
  logic       sc_we = 1'b0;
  logic [7:0] tx_d = 8'h00;
  logic       tx_v = 1'b0;
  logic [7:0] rx_c = 8'h00;
  logic       rx_s = 1'b0;
  logic       rx_p = 1'b0;
  logic       ind = 1'b0;
  logic       slow = 1'b0;
  logic [7:0] r;
  logic [7:0] cq [0:3] = '{8'h80, 8'h01, 8'hAB, 8'h02};
  logic [7:0] sp [0:2] = '{8'h07, 8'h0F, 8'h47};
  logic [7:0] sv [0:2] = '{8'hFF, 8'h55, 8'h00};
  logic [2:0] sk [0:2] = '{3'h1, 3'h3, 3'h2};
  wire  [7:0] ltx_d, rx_d, sync_c;
  wire  [2:0] cls;
  wire        tx_rdy, ltx_v, ltx_r, lead, rx_v, chg, sirq, pirq, synced;
  int         fails = 0, samples_checked = 0, n_fwd = 0, n_chg = 0, n_sirq = 0, n_pirq = 0;
  int         bf, bc, bs, bp, b, i, k;
  xcs_channel uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_channel_option_reg_b(opt_b),
    .i_channel_option_reg_c(opt_c), .i_sync_char_wdata(sc_wd), .i_sync_char_we(sc_we),
    .i_special_char_1(sp[0]), .i_special_char_2(sp[1]), .i_special_char_3(sp[2]),
    .i_extended_mode(1'b1), .i_tx_data(tx_d), .i_tx_valid(tx_v), .o_tx_ready(tx_rdy),
    .o_line_tx_data(ltx_d), .o_line_tx_valid(ltx_v), .i_line_tx_ready(ltx_r), .o_ctrl_lead(lead),
    .i_rx_char(rx_c), .i_rx_strobe(rx_s), .i_rx_partial(rx_p), .i_indication_lead(ind),
    .o_rx_data(rx_d), .o_rx_valid(rx_v), .o_cond_class(cls), .o_cond_change(chg),
    .o_sync_irq(sirq), .o_special_irq(pirq), .o_char_synced(synced), .o_sync_char(sync_c));
  xcs_line_model lm (.i_mclk(i_mclk), .i_valid(ltx_v), .i_data(ltx_d), .i_slow(slow), .o_ready(ltx_r));
  always #25 i_mclk = ~i_mclk;
  // event tallies; scenarios compare their growth
  always @(posedge i_mclk) begin
    n_fwd <= n_fwd + (rx_v === 1'b1);
    n_chg <= n_chg + (chg === 1'b1);
    n_sirq <= n_sirq + (sirq === 1'b1);
    n_pirq <= n_pirq + (pirq === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // byte held until the edge that sees ready; caller stands on an edge
  task automatic send(input logic [7:0] d);
    int g;
    g = 0;
    tx_d <= d;
    tx_v <= 1'b1;
    do begin
      @(posedge i_mclk);
      g++;
    end while (tx_rdy !== 1'b1 && g < 2000);
  endtask
  task automatic cmd(input logic [7:0] l, input logic [7:0] c, input logic [7:0] n);
    send(8'h80);
    send(l);
    send(c);
    send(n);
  endtask
  task automatic drain(input int n);
    int g;
    tx_v <= 1'b0;
    for (g = 0; g < 3000 && lm.n_got < n; g++) @(posedge i_mclk);
  endtask
  task automatic rxc(input logic [7:0] c, input logic p);
    @(posedge i_mclk);
    rx_c <= c;
    rx_p <= p;
    rx_s <= 1'b1;
    @(posedge i_mclk);
    rx_s <= 1'b0;
    repeat (3) @(posedge i_mclk);
  endtask
  task automatic rxn(input logic [7:0] c, input int n);
    repeat (n) rxc(c, 1'b0);
  endtask
  // single sync select stays clear in every group
  task automatic grp(input logic [7:0] c);
    opt_c <= c;
    repeat (4) @(posedge i_mclk);
    bf = n_fwd;
    bc = n_chg;
    bs = n_sirq;
    bp = n_pirq;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    r = 8'($urandom(56));
    repeat (4) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    chk(sync_c, 8'h16);
    cmd(8'h01, 8'hAB, 8'h02);
    drain(4);
    for (i = 0; i < 4; i++) chk(lm.got[i], cq[i]);
    opt_b <= 8'h20;
    slow <= 1'b1;
    cmd(8'h01, 8'hAB, 8'h03);
    drain(7);
    chk(lead, 1'b1);
    cmd(8'h05, 8'hCC, 8'h02);
    drain(9);
    chk(lead, 1'b1);
    for (i = 4; i < 9; i++) chk(lm.got[i], i < 7 ? 8'hAB : 8'hCC);
    send(r & 8'h3F);
    cmd(8'h00, 8'h55, 8'h00);
    send(8'h5A); // new data is already waiting during the repeat
    tx_v <= 1'b0;
    for (k = 0; k < 3000 && lm.got[lm.n_got - 1] !== 8'h5A; k++) @(posedge i_mclk);
    chk(lm.got[9], r & 8'h3F);
    chk(lm.n_got > 13, 1'b1);
    for (i = 10; i < lm.n_got - 1; i++) chk(lm.got[i], 8'h55);
    chk(lead, 1'b0);
    slow <= 1'b0;
    grp(8'h00);
    rxn(8'hFF, 3);
    chk(n_fwd - bf, 3);
    chk(n_chg - bc, 0);
    grp(8'h70);
    rxn(sp[0], 2);
    chk(n_pirq - bp, 0);
    rxc(8'h30 | (r >> 4), 1'b0);
    rxc(8'h38, 1'b1);
    chk(rx_d, 8'h38);
    chk(n_fwd - bf, 4);
    rxn(8'h16, 4);
    chk(n_sirq - bs, 1);
    chk(n_fwd - bf, 6);
    chk(cls, 3'h4);
    for (k = 0; k < 3; k++) begin
      b = n_pirq;
      rxn(sp[k], 3);
      chk(n_pirq - b, 1);
    end
    chk(cls, 3'h5);
    for (k = 0; k < 3; k++) begin
      b = n_chg;
      rxn(sv[k], 3);
      chk(n_chg - b, 1);
      chk(cls, sk[k]);
    end
    // indication lead moves between two ones, so that pair must not validate
    b = n_chg;
    rxc(8'hFF, 1'b0);
    ind <= 1'b1;
    repeat (3) @(posedge i_mclk);
    rxn(8'hFF, 1);
    chk(n_chg - b, 0);
    rxn(8'hFF, 1);
    chk(n_chg - b, 1);
    grp(8'h40);
    sc_wd <= 8'h2D;
    sc_we <= 1'b1;
    @(posedge i_mclk);
    sc_we <= 1'b0;
    repeat (2) @(posedge i_mclk);
    chk(sync_c, 8'h2D);
    rxn(8'h2D, 3);
    chk(n_fwd - bf, 3);
    chk(n_sirq - bs, 0);
    chk(synced, 1'b1);
    tally_and_finish;
  end
  // watchdog: the run needs well under 10000 cycles
  initial begin
    #(50 * 40000);
    fails++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
